// File: rcf_map.svh
// rcf_map.svh: offsets, field positions, reset value and masks of the
// reset-cause flag register.
// assumes: included by bare name; holds definitions only.
`ifndef RCF_MAP_SVH
`define RCF_MAP_SVH

// register map (byte address on the APB side)
`define RCF_ADDR_WIDTH        12
`define RCF_FLAGS_ADDR        12'h000

// field positions inside reset_cause_flags
`define RCF_STACK_OVF_BIT     7
`define RCF_STACK_UNF_BIT     6
`define RCF_UNUSED_BIT        5
`define RCF_WATCHDOG_BIT      4
`define RCF_PIN_BIT           3
`define RCF_INSTR_BIT         2
`define RCF_POWER_ON_BIT      1
`define RCF_BROWN_OUT_BIT     0

// value after power-on: stack flags low, armed flags high, supply flags low
`define RCF_RESET_VALUE       8'h1c
// value loaded by a power-on or brown-out, bits other than power-on
`define RCF_SUPPLY_LOAD       8'h1c
// bit 5 is not implemented and never holds a one
`define RCF_WRITE_MASK        8'hdf

// apb answer: zero wait states, data in the low byte
`define RCF_DATA_WIDTH        8
`define RCF_BYTE_LANE         0

`endif

// File: rcf_pkg.sv
// rcf_pkg.sv: types shared by the reset-cause flag block.
// assumes: rcf_map.svh is in the include path.
`default_nettype none

package rcf_pkg;

	// one-cycle pulses from the reset logic, one per reset source
	typedef struct packed {
		logic power_on;
		logic brown_out;
		logic reset_instr;
		logic master_clear;
		logic watchdog;
		logic stack_underflow;
		logic stack_overflow;
	} rcf_cause_t;

	// register layout, msb first, matches the bit positions of the map
	typedef struct packed {
		logic stack_overflow_flag;
		logic stack_underflow_flag;
		logic unused;
		logic watchdog_reset_flag;
		logic pin_reset_flag;
		logic reset_instruction_flag;
		logic power_on_flag;
		logic brown_out_flag;
	} rcf_flags_t;

	// what the bus slave hands to the flag logic
	typedef struct packed {
		logic       write;
		logic [7:0] data;
	} rcf_wr_t;

endpackage

`default_nettype wire

// File: rcf_apb_slave.sv
// rcf_apb_slave.sv: apb slave for the single flag register.
// assumes: apb master keeps the request stable until pready is sampled;
// zero wait states, read data captured in the setup cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module rcf_apb_slave
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic [`RCF_ADDR_WIDTH-1:0]    paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output var  logic [31:0]                   prdata,
	output var  logic                          pready,
	output var  logic                          pslverr,
	output var  rcf_pkg::rcf_wr_t              reg_wr,
	input  wire rcf_pkg::rcf_flags_t           reg_rdata
);
	import rcf_pkg::*;

	logic        hit;
	logic [31:0] next_prdata;

	// one register only: anything else answers with an error
	assign hit     = (paddr == `RCF_FLAGS_ADDR);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// write lands at the access edge; lanes other than byte 0 are dropped
	always_comb
	begin
		reg_wr.write = psel & penable & pwrite & hit & pstrb[`RCF_BYTE_LANE];
		reg_wr.data  = pwdata[`RCF_DATA_WIDTH-1:0];
	end

	// read snapshot taken at the end of setup, zero-padded above bit 7
	always_comb
	begin
		next_prdata = prdata;
		if (psel & ~penable & ~pwrite)
		begin
			if (hit)
				next_prdata = {24'h00_0000, reg_rdata};
			else
				next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else
			prdata <= next_prdata;
	end

endmodule

`default_nettype wire

// File: rcf_flags.sv
// rcf_flags.sv: reset-cause flag register with its apb slave.
// assumes: cause pulses are one pclk cycle wide and synchronous to pclk;
// presetn is the power-on reset of this block only, other resets of the
// device arrive as cause pulses so the flags survive them.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

// How it works
// - stack overflow sets bit 7, held until firmware writes zero or a supply reset loads 0x1c.
// - stack underflow sets bit 6; firmware clears it by writing zero.
// - watchdog reset clears bit 4, master-clear pin reset clears bit 3.
// - the reset instruction clears bit 2; firmware may set it again.
// - power-on clears bit 1, brown-out bit 0; other resets keep both.
module rcf_flags
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire rcf_pkg::rcf_cause_t           cause,
	input  wire logic [`RCF_ADDR_WIDTH-1:0]    paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output var  logic [31:0]                   prdata,
	output var  logic                          pready,
	output var  logic                          pslverr,
	output var  rcf_pkg::rcf_flags_t           reset_cause_flags
);
	import rcf_pkg::*;

	rcf_wr_t    fw_wr;
	rcf_flags_t next_reset_cause_flags;
	logic       supply_event;

	// bus slave: decode, error answer and read snapshot
	rcf_apb_slave u_apb
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.paddr     (paddr),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.pwdata    (pwdata),
		.pstrb     (pstrb),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.reg_wr    (fw_wr),
		.reg_rdata (reset_cause_flags)
	);

	// a supply reset restarts every flag except bit 1 on a brown-out, so it outranks all other causes
	function automatic logic is_supply(input rcf_cause_t c);
		is_supply = c.power_on | c.brown_out;
	endfunction

	// hardware view of a reset: applied after the firmware write so that an
	// event in the same cycle as a write is never lost
	function automatic rcf_flags_t apply_causes(input rcf_flags_t cur,
		input rcf_cause_t c);
		rcf_flags_t n;
		n = cur;
		if (is_supply(c))
		begin
			n = rcf_flags_t'(`RCF_SUPPLY_LOAD);
			n.power_on_flag = cur.power_on_flag;
			if (c.power_on)
				n.power_on_flag = 1'b0;
		end
		else
		begin
			if (c.stack_overflow)
				n.stack_overflow_flag = 1'b1;
			if (c.stack_underflow)
				n.stack_underflow_flag = 1'b1;
			if (c.watchdog)
				n.watchdog_reset_flag = 1'b0;
			if (c.master_clear)
				n.pin_reset_flag = 1'b0;
			if (c.reset_instr)
				n.reset_instruction_flag = 1'b0;
		end
		n.unused = 1'b0;
		apply_causes = n;
	endfunction

	assign supply_event = is_supply(cause);

	// next flags: firmware write first, then the reset causes on top;
	// all implemented bits are writable, bit 5 is masked off
	always_comb
	begin
		next_reset_cause_flags = reset_cause_flags;
		if (fw_wr.write)
			next_reset_cause_flags =
				rcf_flags_t'(fw_wr.data & `RCF_WRITE_MASK);
		next_reset_cause_flags =
			apply_causes(next_reset_cause_flags, cause);
	end

	// flag storage; presetn acts as the power-on load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_cause_flags <= rcf_flags_t'(`RCF_RESET_VALUE);
		else
			reset_cause_flags <= next_reset_cause_flags;
	end

	// checks

	default clocking cb @(posedge pclk);
	endclocking

	default disable iff (!presetn);

	// a reset pulse that is not a supply reset
	sequence plain_cause_s(ev);
		ev && !supply_event;
	endsequence

	// a firmware write with no reset cause in the same cycle
	sequence quiet_write_s;
		fw_wr.write && (cause == '0);
	endsequence

	// nothing touches the register for one cycle
	sequence idle_s;
		!fw_wr.write && (cause == '0);
	endsequence

	// overflow reset sets bit 7 on the next edge
	ovf_set_a: assert property (
		plain_cause_s(cause.stack_overflow)
		|=> reset_cause_flags[`RCF_STACK_OVF_BIT])
	else $error("stack overflow flag not set after overflow reset");

	// once set, bit 7 stays set through idle cycles and plain resets
	ovf_hold_a: assert property (
		(reset_cause_flags.stack_overflow_flag && !fw_wr.write
			&& !supply_event)
		|=> reset_cause_flags.stack_overflow_flag)
	else $error("stack overflow flag dropped without a write");

	// underflow reset sets bit 6, and bit 6 never rises on its own
	unf_set_a: assert property (
		plain_cause_s(cause.stack_underflow)
		|=> reset_cause_flags[`RCF_STACK_UNF_BIT])
	else $error("stack underflow flag not set after underflow reset");

	unf_cause_a: assert property (
		$rose(reset_cause_flags.stack_underflow_flag)
		|-> $past(cause.stack_underflow) || $past(fw_wr.write))
	else $error("stack underflow flag rose with no cause");

	// watchdog and pin resets clear their bits
	wdt_clear_a: assert property (
		plain_cause_s(cause.watchdog)
		|=> !reset_cause_flags[`RCF_WATCHDOG_BIT])
	else $error("watchdog flag not cleared by watchdog reset");

	pin_clear_a: assert property (
		plain_cause_s(cause.master_clear)
		|=> !reset_cause_flags[`RCF_PIN_BIT])
	else $error("pin flag not cleared by master-clear reset");

	// reset instruction clears bit 2 and it stays low while idle
	instr_clear_a: assert property (
		plain_cause_s(cause.reset_instr) ##1 idle_s
		|=> !reset_cause_flags[`RCF_INSTR_BIT])
	else $error("instruction flag not cleared or not held");

	// power-on clears bit 1; brown-out clears bit 0 and keeps bit 1
	power_clear_a: assert property (
		cause.power_on |=> !reset_cause_flags[`RCF_POWER_ON_BIT]
			&& !reset_cause_flags[`RCF_BROWN_OUT_BIT])
	else $error("supply flags not cleared by power-on reset");

	brown_keep_a: assert property (
		(cause.brown_out && !cause.power_on)
		|=> !reset_cause_flags.brown_out_flag && $stable(
			reset_cause_flags.power_on_flag))
	else $error("brown-out reset mishandled the supply flags");

	// other resets leave the supply flags where they were
	supply_keep_a: assert property (
		(!supply_event && !fw_wr.write)
		|=> $stable(reset_cause_flags[1:0]))
	else $error("supply flags changed on a non-supply reset");

	// supply reset loads the fixed pattern into bits 7 to 2
	supply_load_a: assert property (
		supply_event
		|=> reset_cause_flags[7:2] == (`RCF_SUPPLY_LOAD >> 2))
	else $error("supply reset did not load the stack and armed flags");

	// firmware write lands one edge later, masked, and holds while idle
	fw_write_a: assert property (
		quiet_write_s ##1 idle_s[*2]
		|=> reset_cause_flags ==
			($past(fw_wr.data, 3) & `RCF_WRITE_MASK))
	else $error("firmware write not stored or not held");

	// bit 5 is never one
	bit5_zero_a: assert property (
		!reset_cause_flags[`RCF_UNUSED_BIT]
		&& !prdata[`RCF_UNUSED_BIT])
	else $error("unimplemented bit 5 read as one");

	// bus side: setup of a read, and a write in its access cycle
	sequence rd_setup_s;
		psel && !penable && !pwrite;
	endsequence

	sequence wr_access_s;
		psel && penable && pwrite;
	endsequence

	// only the one mapped offset answers without an error
	err_resp_a: assert property (
		(psel && penable && (paddr != `RCF_FLAGS_ADDR)) |-> pslverr)
	else $error("unmapped access answered without an error");

	ok_resp_a: assert property (
		(psel && penable && (paddr == `RCF_FLAGS_ADDR)) |-> !pslverr)
	else $error("mapped access answered with an error");

	// read data is the flag value seen at the end of setup
	rd_snap_a: assert property (
		rd_setup_s ##0 (paddr == `RCF_FLAGS_ADDR)
		|=> prdata == {24'h00_0000, $past(reset_cause_flags)})
	else $error("read data differs from the flags at setup");

	// unmapped reads return zero, so software never sees stale flags
	rd_miss_a: assert property (
		rd_setup_s ##0 (paddr != `RCF_FLAGS_ADDR)
		|=> prdata == 32'h0000_0000)
	else $error("unmapped read returned data");

	rd_upper_a: assert property (
		prdata[31:8] == 24'h00_0000)
	else $error("read data has bits above the flag byte");

	// a write with byte 0 off, or to another offset, changes nothing
	wr_ignore_a: assert property (
		wr_access_s ##0 ((!pstrb[`RCF_BYTE_LANE]
			|| (paddr != `RCF_FLAGS_ADDR)) && (cause == '0))
		|=> $stable(reset_cause_flags))
	else $error("ignored write changed the flags");

	// in a write cycle an underflow reset still sets bit 6; without one, bit 6 takes the written value
	write_merge_a: assert property (
		(fw_wr.write && !supply_event)
		|=> reset_cause_flags.stack_underflow_flag
			== ($past(fw_wr.data[`RCF_STACK_UNF_BIT])
			|| $past(cause.stack_underflow)))
	else $error("write and underflow reset merged wrongly");

	// once set, bit 6 holds until firmware or a supply reset acts
	unf_hold_a: assert property (
		(reset_cause_flags.stack_underflow_flag && !fw_wr.write
			&& !supply_event)
		|=> reset_cause_flags.stack_underflow_flag)
	else $error("stack underflow flag dropped without a write");

	// bit 7 only rises on an overflow reset or a firmware write
	ovf_cause_a: assert property (
		$rose(reset_cause_flags.stack_overflow_flag)
		|-> $past(cause.stack_overflow) || $past(fw_wr.write))
	else $error("stack overflow flag rose with no cause");

	// armed flags only return to one by a write or a supply reset
	wdt_rise_a: assert property (
		$rose(reset_cause_flags.watchdog_reset_flag)
		|-> $past(fw_wr.write) || $past(supply_event))
	else $error("watchdog flag rose with no write or supply reset");

	pin_rise_a: assert property (
		$rose(reset_cause_flags.pin_reset_flag)
		|-> $past(fw_wr.write) || $past(supply_event))
	else $error("pin flag rose with no write or supply reset");

	instr_rise_a: assert property (
		$rose(reset_cause_flags.reset_instruction_flag)
		|-> $past(fw_wr.write) || $past(supply_event))
	else $error("instruction flag rose with no write or supply reset");

	// no reset ever sets a supply flag; only firmware re-arms them
	pwr_rise_a: assert property (
		$rose(reset_cause_flags.power_on_flag) |-> $past(fw_wr.write))
	else $error("power-on flag rose without a firmware write");

	brown_rise_a: assert property (
		$rose(reset_cause_flags.brown_out_flag) |-> $past(fw_wr.write))
	else $error("brown-out flag rose without a firmware write");

endmodule

`default_nettype wire

// File: tb_top.sv
// tb_top.sv: self-checking bench for the reset-cause flag block.
// assumes: rcf_map.svh, rcf_pkg and rcf_flags compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module tb_top;
	import rcf_pkg::*;
	logic                       pclk;
	logic                       presetn;
	rcf_cause_t                 cause;
	logic [`RCF_ADDR_WIDTH-1:0] paddr;
	logic                       psel;
	logic                       penable;
	logic                       pwrite;
	logic [31:0]                pwdata;
	logic [3:0]                 pstrb;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	rcf_flags_t                 reset_cause_flags;
	logic [31:0]                rd;
	int                         mismatches;
	int                         n_compared;

	rcf_flags DUT
	(
		.pclk              (pclk),
		.presetn           (presetn),
		.cause             (cause),
		.paddr             (paddr),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.pwdata            (pwdata),
		.pstrb             (pstrb),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.reset_cause_flags (reset_cause_flags)
	);

	// 200 MHz core clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one apb transfer; upper lanes carry junk that must be ignored
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [7:0] d, input logic [3:0] s, input logic e_err,
		output logic [31:0] r);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'ha5_a5a5, d};
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench watchdog may end this wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		chk(32'(pslverr), 32'(e_err));
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// flags settle at the causing edge and are checked half a cycle later, on the falling edge
	task automatic flg(input logic [7:0] e);
		@(negedge pclk);
		chk(32'(reset_cause_flags), 32'(e));
	endtask

	task automatic pulse(input rcf_cause_t c);
		@(posedge pclk);
		cause <= c;
		@(posedge pclk);
		cause <= '0;
	endtask

	task automatic t_reset;
		flg(8'h1c);
		apb(0, `RCF_FLAGS_ADDR, 8'h00, 4'h1, 0, rd);
		chk(rd, 32'h0000_001c);
		apb(1, `RCF_FLAGS_ADDR, 8'h1f, 4'h1, 0, rd);
		flg(8'h1f);
		$display("test reset done");
	endtask

	task automatic t_write;
		apb(1, `RCF_FLAGS_ADDR, 8'hff, 4'h1, 0, rd);
		flg(8'hdf);
		apb(0, `RCF_FLAGS_ADDR, 8'h00, 4'h1, 0, rd);
		chk(rd, 32'h0000_00df);
		apb(1, `RCF_FLAGS_ADDR, 8'h1f, 4'he, 0, rd);
		flg(8'hdf);
		apb(1, 12'h004, 8'h00, 4'h1, 1, rd);
		flg(8'hdf);
		apb(0, 12'h004, 8'h00, 4'h1, 1, rd);
		chk(rd, 32'h0000_0000);
		apb(1, `RCF_FLAGS_ADDR, 8'h1f, 4'h1, 0, rd);
		$display("test write done");
	endtask

	// each source in turn, flags accumulate from 0x1f
	task automatic t_causes;
		rcf_cause_t c[7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
		logic [7:0] e[7] = '{8'h9f, 8'hdf, 8'hcf, 8'hc7, 8'hc3, 8'h1e, 8'h1c};
		for (int i = 0; i < 7; i++)
		begin
			pulse(c[i]);
			flg(e[i]);
		end
		pulse(7'h0c);
		flg(8'h04);
		$display("test causes done");
	endtask

	// hardware event in the access cycle beats the firmware write
	task automatic t_race;
		fork
			apb(1, `RCF_FLAGS_ADDR, 8'h10, 4'h1, 0, rd);
			begin
				repeat (2) @(posedge pclk);
				cause <= 7'h04;
				@(posedge pclk);
				cause <= '0;
			end
		join
		flg(8'h00);
		pulse(7'h01);
		flg(8'h80);
		apb(1, `RCF_FLAGS_ADDR, 8'h00, 4'h1, 0, rd);
		flg(8'h00);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		flg(8'h1c);
		$display("test race done");
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		mismatches++;
		test_done();
	end

	initial
	begin
		presetn = 1'b0;
		cause   = '0;
		paddr   = '0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		pwdata  = '0;
		pstrb   = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_write();
		t_causes();
		t_race();
		test_done();
	end
endmodule

`default_nettype wire
